//--- bicm_top.v
`timescale 1ns/1ps
`include "bicm_defines.vh"

module bicm_top
(
  input  wire                      clk,
  input  wire                      rst,
  input  wire [3:0]                slot0_req_n,
  input  wire [3:0]                slot1_req_n,
  input  wire [3:0]                slot2_req_n,
  input  wire [3:0]                slot3_req_n,
  input  wire [3:0]                slot4_req_n,
  input  wire                      disk_primary_req_n,
  input  wire                      rtc_wake_req_n,
  input  wire                      disk_secondary_req_n,
  input  wire                      io_mgmt_req_n,
  input  wire                      network_req_n,
  input  wire [2:0]                spare_a_req_n,
  input  wire                      power_button_req_n,
  input  wire                      pme_a_req_n,
  input  wire                      smart_card_req_n,
  input  wire                      pme_b_req_n,
  input  wire                      audio_req_n,
  input  wire                      spare_b_req_n,
  input  wire                      usb_high_speed_req_n,
  input  wire                      usb_full_speed_req_n,
  input  wire [1:0]                spare_c_req_n,
  input  wire                      serial_port_req,
  input  wire                      parallel_port_req,
  input  wire                      two_wire_device_req,
  input  wire                      overtemp_req,
  output reg                       irq_valid,
  output reg  [`BICM_CODE_W-1:0]   irq_code,
  output reg  [`BICM_LEVEL_W-1:0]  irq_level,
  output reg  [`BICM_NUM_SRC-1:0]  irq_pending
);

  wire [`BICM_NUM_SRC-1:0]  req_raw;
  wire [`BICM_NUM_SRC-1:0]  pending;
  wire                      found;
  wire [`BICM_IDX_W-1:0]    win_idx;
  wire [`BICM_LEVEL_W-1:0]  win_level;
  reg  [`BICM_CODE_W-1:0]   next_code;

  // Index width copy of the low-run length keeps the code arithmetic at six bits
  localparam [`BICM_IDX_W-1:0] low_count = `BICM_NUM_LOW;

  // Index order follows code order; slot lines A..D sit in bits 0..19, four per slot, slot 0 in bits 0..3
  assign req_raw = {overtemp_req,
                    two_wire_device_req,
                    parallel_port_req, serial_port_req,
                    spare_c_req_n,
                    usb_full_speed_req_n, usb_high_speed_req_n,
                    spare_b_req_n, audio_req_n,
                    pme_b_req_n,
                    smart_card_req_n,
                    pme_a_req_n,
                    power_button_req_n,
                    spare_a_req_n, network_req_n,
                    io_mgmt_req_n,
                    disk_secondary_req_n,
                    rtc_wake_req_n,
                    disk_primary_req_n,
                    slot4_req_n,
                    slot3_req_n,
                    slot2_req_n,
                    slot1_req_n,
                    slot0_req_n};

  bicm_sense
  #(
    .NUM_SRC  (`BICM_NUM_SRC),
    .POL_HIGH (`BICM_POL_HIGH_MASK)
  )
  u_sense
  (
    .clk     (clk),
    .rst     (rst),
    .req_raw (req_raw),
    .pending (pending)
  );

  // Levels per index come from the priority table
  bicm_arbiter
  #(
    .NUM_SRC (`BICM_NUM_SRC),
    .PRI     (`BICM_PRI_TABLE)
  )
  u_arb
  (
    .pending   (pending),
    .found     (found),
    .win_idx   (win_idx),
    .win_level (win_level)
  );

  // Index to code: low run starts at 0x04, high run skips 0x2A and 0x2B
  always @*
  begin
    if (!found)
      next_code = `BICM_CODE_NONE;
    else if (win_idx < low_count)
      next_code = win_idx + `BICM_CODE_LOW_BASE;
    else
      next_code = win_idx - low_count + `BICM_CODE_HIGH_BASE;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_valid   <= 1'b0;
      irq_code    <= `BICM_CODE_NONE;
      irq_level   <= `BICM_LEVEL_NONE;
      irq_pending <= {`BICM_NUM_SRC{1'b0}};
    end
    else
    begin
      irq_valid   <= found;
      irq_code    <= next_code;
      irq_level   <= found ? win_level : `BICM_LEVEL_NONE;
      irq_pending <= pending;
    end
  end

endmodule

//--- bicm_defines.vh
`ifndef BICM_DEFINES_VH
`define BICM_DEFINES_VH

// Source count: 38 active-low inputs then 4 active-high inputs
`define BICM_NUM_SRC      42
`define BICM_NUM_LOW      38
`define BICM_CODE_W       6
`define BICM_LEVEL_W      4
`define BICM_IDX_W        6

// First code of the active-low run and of the active-high run
`define BICM_CODE_LOW_BASE  6'h04
`define BICM_CODE_HIGH_BASE 6'h2C
`define BICM_CODE_NONE      6'h00
`define BICM_LEVEL_NONE     4'h0

// Polarity per source index: 1 = active high
`define BICM_POL_HIGH_MASK  42'h3C000000000

// Priority level per source index, index 0 in the low nibble
`define BICM_PRI_TABLE      168'h874387458852337654311666643112765444444444

`endif

//--- bicm_sense.v
`timescale 1ns/1ps
`include "bicm_defines.vh"

// Normalises each request to active high and holds it as a pending level
module bicm_sense
#(
  parameter                  NUM_SRC  = `BICM_NUM_SRC,
  parameter [NUM_SRC-1:0]    POL_HIGH = `BICM_POL_HIGH_MASK
)
(
  input  wire                clk,
  input  wire                rst,
  input  wire [NUM_SRC-1:0]  req_raw,
  output reg  [NUM_SRC-1:0]  pending
);

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i = i + 1)
    begin : g_src
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          pending[i] <= 1'b0;
        else
          pending[i] <= POL_HIGH[i] ? req_raw[i] : ~req_raw[i];
      end
    end
  endgenerate

endmodule

//--- bicm_arbiter.v
`timescale 1ns/1ps
`include "bicm_defines.vh"

// Picks the pending source with the highest level; ties go to the lower code
module bicm_arbiter
#(
  parameter                        NUM_SRC = `BICM_NUM_SRC,
  parameter [NUM_SRC*4-1:0]        PRI     = `BICM_PRI_TABLE
)
(
  input  wire [NUM_SRC-1:0]        pending,
  output reg                       found,
  output reg  [`BICM_IDX_W-1:0]    win_idx,
  output reg  [`BICM_LEVEL_W-1:0]  win_level
);

  integer k;

  always @*
  begin
    found     = 1'b0;
    win_idx   = {`BICM_IDX_W{1'b0}};
    win_level = `BICM_LEVEL_NONE;
    for (k = 0; k < NUM_SRC; k = k + 1)
    begin
      if (pending[k] && (!found || PRI[k*4 +: 4] > win_level))
      begin
        found     = 1'b1;
        win_idx   = k[`BICM_IDX_W-1:0];
        win_level = PRI[k*4 +: 4];
      end
    end
  end

endmodule

//--- bicm_src.sv
`timescale 1ns/1ps
// Request sources: act bit set means the source wants service
module bicm_src
(
  input  wire logic [41:0] act,
  output wire logic [41:0] raw
);
  // Indices 0..37 drive low when asserted, 38..41 drive high
  assign raw = act ^ 42'h03FFFFFFFFF;
endmodule

//--- bicm_checker.sv
`timescale 1ns/1ps
module bicm_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        audio_req_n,
  input wire logic        serial_port_req,
  input wire logic        irq_valid,
  input wire logic [5:0]  irq_code,
  input wire logic [3:0]  irq_level,
  input wire logic [41:0] irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_audio_fall;
    $fell(audio_req_n);
  endsequence
  sequence s_audio_shown;
    irq_pending[32] && irq_valid && irq_level == 4'h8;
  endsequence
  a_audio_path: assert property (s_audio_fall |=> ##1 s_audio_shown)
    else $error("audio request not shown");
  a_valid_any: assert property (irq_valid == |irq_pending)
    else $error("valid does not follow pending");
  a_valid_rises: assert property (!$past(rst, 2) && !$past(rst) && (!$past(audio_req_n, 2) || $past(serial_port_req, 2)) |-> irq_valid)
    else $error("valid missing for held request");
  a_idle_zero: assert property (!irq_valid |-> irq_code == 6'h00 && irq_level == 4'h0)
    else $error("idle output not zero");
  a_code_legal: assert property (irq_valid |-> irq_code inside {[6'h04:6'h29], [6'h2C:6'h2F]})
    else $error("unassigned code");
  a_audio_wins: assert property (irq_pending[32] |-> irq_code == 6'h24 && irq_level == 4'h8)
    else $error("audio not the winner");
  a_overtemp_top: assert property (irq_pending[41] |-> irq_level == 4'h8)
    else $error("overtemp level wrong");
  a_serial_high: assert property (!$past(rst, 2) && !$past(rst) |-> irq_pending[38] == $past(serial_port_req, 2))
    else $error("serial not sensed high");
  a_pend_clear: assert property (!$past(rst, 2) && !$past(rst) && $past(audio_req_n, 2) |-> !irq_pending[32])
    else $error("audio pending while released");
endmodule
bind bicm_top bicm_checker bicm_checker_i (.clk(clk), .rst(rst), .audio_req_n(audio_req_n),
  .serial_port_req(serial_port_req), .irq_valid(irq_valid), .irq_code(irq_code),
  .irq_level(irq_level), .irq_pending(irq_pending));

//--- tb_top.sv
`timescale 1ns/1ps
`define CMP(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        clk;
  logic        rst;
  logic [41:0] act;
  logic [41:0] raw;
  logic        irq_valid;
  logic [5:0]  irq_code;
  logic [3:0]  irq_level;
  logic [41:0] irq_pending;
  integer      seed;
  integer      fails;
  integer      n_compared;
  integer      cycles = 0;
  localparam logic [167:0] LVL = 168'h874387458852337654311666643112765444444444;

  // Highest level wins, ties to the lower index
  function automatic logic [9:0] ref_win(input logic [41:0] p);
    logic [9:0] w;
    w = 10'h000;
    for (int i = 0; i < 42; i++)
      if (p[i] && LVL[i*4+:4] > w[3:0])
        w = {(i < 38) ? 6'(i + 4) : 6'(i + 6), LVL[i*4+:4]};
    return w;
  endfunction

  bicm_src bicm_src_i (.act(act), .raw(raw));
  bicm_top bicm_top_i
  (
    .clk(clk), .rst(rst), .slot0_req_n(raw[3:0]), .slot1_req_n(raw[7:4]),
    .slot2_req_n(raw[11:8]), .slot3_req_n(raw[15:12]), .slot4_req_n(raw[19:16]),
    .disk_primary_req_n(raw[20]), .rtc_wake_req_n(raw[21]), .disk_secondary_req_n(raw[22]),
    .io_mgmt_req_n(raw[23]), .network_req_n(raw[24]), .spare_a_req_n(raw[27:25]),
    .power_button_req_n(raw[28]), .pme_a_req_n(raw[29]), .smart_card_req_n(raw[30]),
    .pme_b_req_n(raw[31]), .audio_req_n(raw[32]), .spare_b_req_n(raw[33]),
    .usb_high_speed_req_n(raw[34]), .usb_full_speed_req_n(raw[35]),
    .spare_c_req_n(raw[37:36]), .serial_port_req(raw[38]), .parallel_port_req(raw[39]),
    .two_wire_device_req(raw[40]), .overtemp_req(raw[41]), .irq_valid(irq_valid),
    .irq_code(irq_code), .irq_level(irq_level), .irq_pending(irq_pending)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
  end

  task apply(input logic [41:0] v);
    logic [9:0] w;
    @(posedge clk);
    #2 act = v;
    repeat (2) @(posedge clk);
    #1 w = ref_win(v);
    `CMP("pending", v, irq_pending)
    `CMP("valid", |v, irq_valid)
    `CMP("code", w[9:4], irq_code)
    `CMP("level", w[3:0], irq_level)
  endtask

  initial
  begin
    seed = 32'h088EDB53;
    fails = 0;
    n_compared = 0;
    act = 42'h0;
    rst = 1'b1;
    fork
      begin
        repeat (2) @(posedge clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 42; i++)
          apply(42'h1 << i);
        $display("single source test done");
        apply({42{1'b1}});
        apply(42'h0);
        repeat (200) apply(42'({$random(seed), $random(seed)}));
        $display("random test done");
        @(posedge clk);
        #2 rst = 1'b1;
        #1 `CMP("reset valid", 1'b0, irq_valid)
        `CMP("reset code", 6'h00, irq_code)
        `CMP("reset level", 4'h0, irq_level)
        `CMP("reset pending", 42'h0, irq_pending)
        @(posedge clk);
        #2 rst = 1'b0;
        apply(42'h1 << 41);
        $display("reset test done");
      end
      begin
        wait (cycles >= 3000);
        fails++;
      end
    join_any
    finish_test();
  end
endmodule
